// ### design/rtcy_regs.sv
// Overview of operation
// RL1: year is two bcd digits 00..99
// RL2: leap year flagged correctly 2000 through 2099
// RL3: minute alarm bit 7 low enables compare
// RL4: minute compare value bcd in bits 6:0
// RL5: hour alarm bit 7 low enables compare
// RL6: 24-hour mode compares bcd hours bits 5:0
// RL7: 12-hour mode compares bcd hours bits 4:0
// RL8: 12-hour mode bit 5 is afternoon flag
// RL9: host rewrites hour alarm after mode change
// RL10: reads always allowed, locked writes ignored
// RL11: alarm only when all enabled fields match
// RL12: hour alarm bit 6 reads zero, ignores writes
// RL13: reset gives year 00, alarms 80 hex
module rtcy_regs
    import rtcy_pkg::*;
(
    input  wire logic       clk_sys,              // 125 MHz system clock
    input  wire logic       nrst,                 // async reset, active low
    input  wire logic       clk_en,               // freezes all state while low
    input  wire logic       reg_wr,               // register write strobe
    input  wire logic       reg_rd,               // register read strobe
    input  wire logic [7:0] reg_addr,             // register offset
    input  wire logic [7:0] reg_wdata,            // write data
    output logic      [7:0] reg_rdata,            // read data, one cycle after strobe
    input  wire logic       write_locked,         // password protection active
    input  wire logic       hour_mode_12,         // twelve-hour select
    input  wire logic       year_tick,            // one-cycle pulse: year rolls over
    input  wire logic [6:0] cur_minutes,          // live bcd minutes
    input  wire logic [5:0] cur_hours,            // live bcd hours, format per mode
    input  wire logic       dayfield_alarm_disable, // weekday/date field disable
    input  wire logic       dayfield_match,       // weekday/date field equal
    output logic      [7:0] year_value,           // current bcd year
    output logic            leap_year,            // current year is a leap year
    output logic            minute_alarm_disable, // minute compare disabled
    output logic            hour_alarm_disable,   // hour compare disabled
    output logic            alarm_match           // all enabled fields match
);
    // register state
    logic [7:0] year_q;      // bcd year
    logic [7:0] year_d;      // next year
    logic [7:0] min_alm_q;   // minute alarm register
    logic [7:0] min_alm_d;   // next minute alarm
    logic [7:0] hour_alm_q;  // hour alarm register
    logic [7:0] hour_alm_d;  // next hour alarm
    logic [7:0] rdata_q;     // read data holding register
    logic [7:0] rdata_d;     // next read data
    logic       leap_q;      // leap flag of the stored year
    logic       leap_d;      // leap flag of the next year
    logic       match_q;     // registered alarm condition
    logic       match_d;     // next alarm condition
    // decode
    logic       wr_ok;       // write accepted
    logic       min_hit;     // minute field satisfied
    logic       hour_hit;    // hour field satisfied
    logic [3:0] yr_lo;       // year units digit
    logic [3:0] yr_hi;       // year tens digit

    // writes pass only while protection is off
    always_comb begin
        wr_ok = reg_wr & ~write_locked; // RL10
    end

    // year: host write wins over the rollover tick
    always_comb begin
        year_d = year_q;
        yr_lo  = year_q[3:0];
        yr_hi  = year_q[7:4];
        if (wr_ok && reg_addr == RTCY_OFS_YEAR) begin
            year_d = reg_wdata;
        end else if (year_tick) begin
            // bcd increment with 99 wrapping to 00
            if (year_q == RTCY_YEAR_LAST) begin
                year_d = RTCY_RST_YEAR; // RL1
            end else if (yr_lo == RTCY_BCD_NINE) begin
                year_d = {yr_hi + 4'h1, RTCY_BCD_ZERO}; // RL1
            end else begin
                year_d = {yr_hi, yr_lo + 4'h1}; // RL1
            end
        end
    end

    // leap when bcd year divisible by four: even tens with 0/4/8, odd tens with 2/6
    always_comb begin
        if (year_d[4] == 1'h0) begin
            leap_d = (year_d[3:0] == 4'h0) | (year_d[3:0] == 4'h4)
                   | (year_d[3:0] == 4'h8); // RL2
        end else begin
            leap_d = (year_d[3:0] == 4'h2) | (year_d[3:0] == 4'h6); // RL2
        end
    end

    // alarm registers: full byte for minutes, bit 6 forced low for hours
    always_comb begin
        min_alm_d  = min_alm_q;
        hour_alm_d = hour_alm_q;
        if (wr_ok && reg_addr == RTCY_OFS_MIN_ALM) begin
            min_alm_d = reg_wdata & RTCY_MASK_MIN_ALM; // RL3 RL4
        end
        if (wr_ok && reg_addr == RTCY_OFS_HOUR_ALM) begin
            hour_alm_d = reg_wdata & RTCY_MASK_HOUR_ALM; // RL5 RL12
        end
    end

    // read mux: always readable, unmapped offsets return zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                RTCY_OFS_YEAR:     rdata_d = year_q; // RL10
                RTCY_OFS_MIN_ALM:  rdata_d = min_alm_q; // RL10
                RTCY_OFS_HOUR_ALM: rdata_d = hour_alm_q; // RL10 RL12
                default:           rdata_d = RTCY_READ_NONE;
            endcase
        end
    end

    // minute field compare
    rtcy_field_cmp #(
        .W (7)
    ) u_min_cmp (
        .disable_bit (min_alm_q[RTCY_BIT_DISABLE]),
        .alarm_val   (min_alm_q[6:0]),
        .cur_val     (cur_minutes),
        .hit         (min_hit)
    );

    // hour field compare: bits 5:0 cover 24h hours, or 12h hours plus afternoon flag
    rtcy_field_cmp #(
        .W (6)
    ) u_hour_cmp (
        .disable_bit (hour_alm_q[RTCY_BIT_DISABLE]),
        .alarm_val   (hour_alm_q[5:0]),
        .cur_val     (cur_hours), // RL6 RL7 RL8
        .hit         (hour_hit)
    );

    // alarm needs at least one enabled field and every enabled field matching
    always_comb begin
        match_d = min_hit & hour_hit
                & (dayfield_alarm_disable | dayfield_match) // RL11
                & ~(min_alm_q[RTCY_BIT_DISABLE] & hour_alm_q[RTCY_BIT_DISABLE]
                    & dayfield_alarm_disable); // RL11
    end

    // state registers, frozen while the clock enable is low
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            year_q     <= RTCY_RST_YEAR; // RL13
            min_alm_q  <= RTCY_RST_MIN_ALM; // RL13
            hour_alm_q <= RTCY_RST_HOUR_ALM; // RL13
            rdata_q    <= RTCY_READ_NONE;
            leap_q     <= 1'h1;
            match_q    <= 1'h0;
        end else if (clk_en) begin
            year_q     <= year_d;
            min_alm_q  <= min_alm_d;
            hour_alm_q <= hour_alm_d;
            rdata_q    <= rdata_d;
            leap_q     <= leap_d;
            match_q    <= match_d;
        end
    end

    // outputs straight from flops
    always_comb begin
        reg_rdata            = rdata_q;
        year_value           = year_q;
        leap_year            = leap_q;
        minute_alarm_disable = min_alm_q[RTCY_BIT_DISABLE];
        hour_alarm_disable   = hour_alm_q[RTCY_BIT_DISABLE];
        alarm_match          = match_q;
    end

    // mode input feeds only the c_pm cover here; hour format lives in the stored value
    logic mode_seen;
    always_comb begin
        mode_seen = hour_mode_12;
    end

    // year digits stay decimal
    property p_year_bcd;
        @(posedge clk_sys) disable iff (!nrst)
        (year_q[3:0] <= 4'h9) && (year_q[7:4] <= 4'h9);
    endproperty
    a_year_bcd: assert property (p_year_bcd) else $error("year not bcd"); // RL1

    // 99 rolls to 00 on a tick with no write
    property p_year_wrap;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && year_tick && !reg_wr && year_q == 8'h99) |=> (year_q == 8'h00);
    endproperty
    a_year_wrap: assert property (p_year_wrap) else $error("year wrap wrong"); // RL1

    // leap flag follows the stored year
    property p_leap;
        @(posedge clk_sys) disable iff (!nrst)
        (year_q == 8'h00 || year_q == 8'h96 || year_q == 8'h12) |-> leap_year;
    endproperty
    a_leap: assert property (p_leap) else $error("leap year missed"); // RL2

    // unlocked minute write lands the whole byte
    property p_min_write;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && reg_wr && !write_locked && reg_addr == 8'h07)
            |=> (min_alm_q == $past(reg_wdata));
    endproperty
    a_min_write: assert property (p_min_write) else $error("minute write lost"); // RL3

    // locked write leaves the hour alarm alone
    property p_locked;
        @(posedge clk_sys) disable iff (!nrst)
        (reg_wr && write_locked) |=> $stable(hour_alm_q) && $stable(min_alm_q);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write took effect"); // RL10

    // unused hour bit stays low
    property p_hour_bit6;
        @(posedge clk_sys) disable iff (!nrst)
        hour_alm_q[6] == 1'h0;
    endproperty
    a_hour_bit6: assert property (p_hour_bit6) else $error("hour bit 6 set"); // RL12

    // alarm needs some enabled field
    property p_alarm_enabled;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(alarm_match) |-> $past(!min_alm_q[7] || !hour_alm_q[7] || !dayfield_alarm_disable);
    endproperty
    a_alarm_enabled: assert property (p_alarm_enabled) // RL11
        else $error("alarm with none enabled");

    // enabled hour field must have matched, afternoon flag included
    property p_hour_match;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && !hour_alm_q[7] && cur_hours != hour_alm_q[5:0]) |=> !alarm_match;
    endproperty
    a_hour_match: assert property (p_hour_match) else $error("hour mismatch alarmed"); // RL6 RL8

    // read returns the register one cycle later
    property p_read_year;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && reg_rd && reg_addr == 8'h06) |=> (reg_rdata == $past(year_q));
    endproperty
    a_read_year: assert property (p_read_year) else $error("year read wrong"); // RL10

    // minute alarm read returns the register one cycle later, lock or not
    property p_read_min;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && reg_rd && reg_addr == RTCY_OFS_MIN_ALM)
            |=> (reg_rdata == $past(min_alm_q));
    endproperty
    a_read_min: assert property (p_read_min) else $error("minute read wrong"); // RL10

    // units digit 9 carries into the tens digit on a tick
    property p_year_carry;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && year_tick && !reg_wr && year_q[3:0] == RTCY_BCD_NINE
            && year_q != RTCY_YEAR_LAST)
            |=> (year_q[3:0] == RTCY_BCD_ZERO) && (year_q[7:4] == $past(year_q[7:4]) + 4'h1);
    endproperty
    a_year_carry: assert property (p_year_carry) else $error("year carry wrong"); // RL1

    // with no tick and no year write the year holds
    property p_year_hold;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && !year_tick && !(reg_wr && reg_addr == RTCY_OFS_YEAR))
            |=> $stable(year_q);
    endproperty
    a_year_hold: assert property (p_year_hold) else $error("year moved unasked"); // RL1

    // years not divisible by four carry no leap flag
    property p_leap_none;
        @(posedge clk_sys) disable iff (!nrst)
        (year_q == 8'h01 || year_q == 8'h05 || year_q == 8'h19 || year_q == 8'h99)
            |-> !leap_year;
    endproperty
    a_leap_none: assert property (p_leap_none) else $error("false leap year"); // RL2

    // unlocked hour write lands with bit 6 cleared
    property p_hour_write;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && reg_wr && !write_locked && reg_addr == RTCY_OFS_HOUR_ALM)
            |=> (hour_alm_q == ($past(reg_wdata) & RTCY_MASK_HOUR_ALM));
    endproperty
    a_hour_write: assert property (p_hour_write) else $error("hour write lost"); // RL5 RL12

    // an enabled minute field that differs blocks the alarm
    property p_min_match;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && !min_alm_q[7] && cur_minutes != min_alm_q[6:0]) |=> !alarm_match;
    endproperty
    a_min_match: assert property (p_min_match) else $error("minute mismatch hit"); // RL4 RL11

    // an enabled day field that differs blocks the alarm
    property p_day_block;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && !dayfield_alarm_disable && !dayfield_match) |=> !alarm_match;
    endproperty
    a_day_block: assert property (p_day_block) else $error("day mismatch alarmed"); // RL11

    // a lone enabled minute field that matches raises the alarm
    property p_min_only;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && !min_alm_q[7] && cur_minutes == min_alm_q[6:0]
            && hour_alm_q[7] && dayfield_alarm_disable) |=> alarm_match;
    endproperty
    a_min_only: assert property (p_min_only) else $error("minute match missed"); // RL3 RL11

    // no enabled field, no alarm
    property p_none_enabled;
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && min_alm_q[7] && hour_alm_q[7] && dayfield_alarm_disable) |=> !alarm_match;
    endproperty
    a_none_enabled: assert property (p_none_enabled) else $error("alarm while disabled"); // RL11

    c_wrap:  cover property (@(posedge clk_sys) disable iff (!nrst) year_tick && year_q == 8'h99);
    c_alarm: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(alarm_match));
    c_lock:  cover property (@(posedge clk_sys) disable iff (!nrst) reg_wr && write_locked);
    c_pm:    cover property (@(posedge clk_sys) disable iff (!nrst)
                             mode_seen && alarm_match && hour_alm_q[5]);
endmodule

// ### design/rtcy_pkg.sv
package rtcy_pkg;
    // register offsets on the register port
    localparam logic [7:0] RTCY_OFS_YEAR     = 8'h06;
    localparam logic [7:0] RTCY_OFS_MIN_ALM  = 8'h07;
    localparam logic [7:0] RTCY_OFS_HOUR_ALM = 8'h08;
    // reset values
    localparam logic [7:0] RTCY_RST_YEAR     = 8'h00;
    localparam logic [7:0] RTCY_RST_MIN_ALM  = 8'h80;
    localparam logic [7:0] RTCY_RST_HOUR_ALM = 8'h80;
    // field positions
    localparam int         RTCY_BIT_DISABLE  = 7;
    localparam int         RTCY_BIT_PM       = 5;
    // writable bit masks (hours bit 6 unused)
    localparam logic [7:0] RTCY_MASK_MIN_ALM  = 8'hFF;
    localparam logic [7:0] RTCY_MASK_HOUR_ALM = 8'hBF;
    // bcd digit limits
    localparam logic [3:0] RTCY_BCD_NINE     = 4'h9;
    localparam logic [3:0] RTCY_BCD_ZERO     = 4'h0;
    localparam logic [7:0] RTCY_YEAR_LAST    = 8'h99;
    localparam logic [7:0] RTCY_READ_NONE    = 8'h00;
endpackage

// ### design/rtcy_field_cmp.sv
// one alarm field compare: hit when the field is disabled or the value matches
module rtcy_field_cmp #(
    parameter int W = 7
) (
    input  wire logic         disable_bit, // high: field takes no part
    input  wire logic [W-1:0] alarm_val,   // stored compare value
    input  wire logic [W-1:0] cur_val,     // live time value
    output logic              hit          // field satisfied
);
    // a disabled field never blocks the alarm
    always_comb begin
        hit = disable_bit | (alarm_val == cur_val);
    end
endmodule

// ### verif/rtcy_host_model.sv
// host side of the register port: one-cycle strobes, lines scrambled when idle
module rtcy_host_model (
    input  wire logic       clk_sys,   // system clock
    output logic            reg_wr,    // write strobe
    output logic            reg_rd,    // read strobe
    output logic      [7:0] reg_addr,  // register offset
    output logic      [7:0] reg_wdata, // write data
    input  wire logic [7:0] reg_rdata  // read data from the device
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // one write strobe; address and data are inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'h1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'h0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    // one read strobe; data is registered at the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_rd   = 1'h1;
        reg_addr = a;
        @(posedge clk_sys);
        #1;
        reg_rd   = 1'h0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask
endmodule

// ### verif/tb_top.sv
// register, year and alarm tests through the host model
module tb_top;
    import rtcy_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

    logic       clk_sys = 1'h0;      // system clock
    logic       nrst = 1'h0;         // reset, active low
    logic       clk_en = 1'h1;       // clock enable
    logic       reg_wr, reg_rd;      // strobes from the host
    logic [7:0] reg_addr, reg_wdata; // address and data from the host
    logic [7:0] reg_rdata;           // read data
    logic       write_locked = 1'h0; // password protection
    logic       hour_mode_12 = 1'h0; // twelve-hour select
    logic       year_tick = 1'h0;    // year advance pulse
    logic [6:0] cur_minutes = 7'h00; // live minutes
    logic [5:0] cur_hours = 6'h00;   // live hours
    logic       day_dis = 1'h1;      // weekday/date field disable
    logic       day_match = 1'h0;    // weekday/date field equal
    logic [7:0] year_value;          // year output
    logic       leap_year, min_dis, hour_dis, alarm_match; // status outputs
    int         n_errors = 0;        // mismatches
    int         n_checks = 0;        // comparisons

    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;

    rtcy_host_model u_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    rtcy_regs u_dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .write_locked(write_locked), .hour_mode_12(hour_mode_12), .year_tick(year_tick),
        .cur_minutes(cur_minutes), .cur_hours(cur_hours), .dayfield_alarm_disable(day_dis),
        .dayfield_match(day_match), .year_value(year_value), .leap_year(leap_year),
        .minute_alarm_disable(min_dis), .hour_alarm_disable(hour_dis),
        .alarm_match(alarm_match));

    // read a register and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        `CHK(d, exp)
    endtask

    // one-cycle year pulse
    task automatic tick();
        @(posedge clk_sys);
        #1;
        year_tick = 1'h1;
        @(posedge clk_sys);
        #1;
        year_tick = 1'h0;
    endtask

    // let the compare settle, then check the match level
    task automatic amatch(input logic exp);
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(alarm_match, exp)
    endtask

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog far beyond the fewer than a hundred cycles the tests need
    initial begin
        #100us;
        n_errors++;
        final_report();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        #1;
        nrst = 1'h1;
        `CHK(leap_year, 1'h1)
        `CHK(min_dis, 1'h1)
        `CHK(hour_dis, 1'h1)
        rchk(RTCY_OFS_YEAR, RTCY_RST_YEAR);
        rchk(RTCY_OFS_MIN_ALM, RTCY_RST_MIN_ALM);
        rchk(RTCY_OFS_HOUR_ALM, RTCY_RST_HOUR_ALM);
        rchk(8'h05, RTCY_READ_NONE);
        u_host.wr(RTCY_OFS_MIN_ALM, 8'h3A);
        `CHK(min_dis, 1'h0)
        rchk(RTCY_OFS_MIN_ALM, 8'h3A);
        u_host.wr(RTCY_OFS_HOUR_ALM, 8'hFF);
        rchk(RTCY_OFS_HOUR_ALM, 8'hBF);
        `CHK(hour_dis, 1'h1)
        // locked, then frozen: both writes must be lost
        write_locked = 1'h1;
        u_host.wr(RTCY_OFS_MIN_ALM, 8'h85);
        rchk(RTCY_OFS_MIN_ALM, 8'h3A);
        write_locked = 1'h0;
        clk_en = 1'h0;
        u_host.wr(RTCY_OFS_MIN_ALM, 8'h85);
        clk_en = 1'h1;
        rchk(RTCY_OFS_MIN_ALM, 8'h3A);
        // year digit carry, wrap and leap flag
        u_host.wr(RTCY_OFS_YEAR, 8'h19);
        tick();
        `CHK(year_value, 8'h20)
        u_host.wr(RTCY_OFS_YEAR, RTCY_YEAR_LAST);
        tick();
        `CHK(year_value, 8'h00)
        `CHK(leap_year, 1'h1)
        u_host.wr(RTCY_OFS_YEAR, 8'h03);
        tick();
        `CHK(leap_year, 1'h1)
        tick();
        `CHK(year_value, 8'h05)
        `CHK(leap_year, 1'h0)
        // alarm compares
        u_host.wr(RTCY_OFS_MIN_ALM, 8'h45);
        cur_minutes = 7'h45;
        amatch(1'h1);
        cur_minutes = 7'h46;
        amatch(1'h0);
        cur_minutes = 7'h45;
        u_host.wr(RTCY_OFS_HOUR_ALM, 8'h23);
        cur_hours = 6'h23;
        amatch(1'h1);
        cur_hours = 6'h03;
        amatch(1'h0);
        hour_mode_12 = 1'h1;
        u_host.wr(RTCY_OFS_HOUR_ALM, 8'h31);
        cur_hours = 6'h31;
        amatch(1'h1);
        cur_hours = 6'h11;
        amatch(1'h0);
        cur_hours = 6'h31;
        day_dis = 1'h0;
        amatch(1'h0);
        day_match = 1'h1;
        amatch(1'h1);
        u_host.wr(RTCY_OFS_MIN_ALM, 8'h80);
        u_host.wr(RTCY_OFS_HOUR_ALM, 8'h80);
        day_dis = 1'h1;
        amatch(1'h0);
        final_report();
    end
endmodule
